// ---- fstc_top.v ----
// filter select and trigger controller: keypad, menu, trigger modes, outputs
//
// Operation
// - index output is 4-bit binary
// - busy line beside index bits
// - dac code equals index times 400 mV
// - four modes, direct at start and deactivate
// - index 0 after startup
// - new index applied immediately
// - keypad index limited to 0..15
// - single digit by leading zero or enter
// - two digits commit after 1 and digit
// - bare enter selects index 0
// - mode then 2, 3, 7 or 8 opens function
// - menu 0 exits, 1 next page
// - last page stays on repeated 1
// - frame mode steps on vertical sync
// - host-loaded index applied on trigger
// - confirm 1 activates, 0 aborts
// - strobe triggers edge advance mode
// - same functions from all three sources; the keypad cannot select direct mode or preload an index
// - start remote if commands wait
// - keys act on release, ignore during move
// - remote ignores keys except local
// - edge mode steps on strobe rise
// - gated mode arms on strobe fall
`default_nettype none
`include "fstc_consts.vh"
module fstc_top #(
  parameter QDEPTH = 16,
  parameter QAW = 4,
  parameter DACW = 13
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // keypad: code held while pressed
  input wire key_down,
  input wire [3:0] key_code,
  // remote command port (serial or parallel, decoded)
  input wire rem_pending,
  input wire rem_sel_valid,
  input wire [3:0] rem_sel_idx,
  input wire rem_mode_valid,
  input wire [1:0] rem_mode,
  input wire rem_fn_valid,
  input wire [3:0] rem_fn,
  input wire rem_load_valid,
  input wire [3:0] rem_load_idx,
  // sequence queue programming
  input wire q_wr_en,
  input wire [QAW-1:0] q_wr_addr,
  input wire [3:0] q_wr_data,
  input wire [QAW-1:0] q_last,
  // trigger inputs
  input wire vsync,
  input wire strobe,
  // outputs
  output reg [3:0] idx_out,
  output reg busy,
  output reg [DACW-1:0] dac_mv,
  output reg [1:0] mode_out,
  output reg remote,
  output reg fn_strobe,
  output reg [3:0] fn_code,
  output reg [3:0] menu_page,
  output reg apply_strobe
);
  // settle count, rounded up
  localparam integer SETTLE_CYC = (`FSTC_SETTLE_NS + `FSTC_CLK_NS - 1) / `FSTC_CLK_NS;
  // menu states: main screen, mode pages, confirm prompt
  localparam [1:0] MS_MAIN = 2'h0;
  localparam [1:0] MS_MENU = 2'h1;
  localparam [1:0] MS_CONF = 2'h2;
  // digit entry: empty, leading zero, one digit, leading one
  localparam [1:0] ES_IDLE = 2'h0;
  localparam [1:0] ES_ZERO = 2'h1;
  localparam [1:0] ES_DIG = 2'h2;
  localparam [1:0] ES_ONE = 2'h3;

  reg [1:0] ms_q;
  reg [1:0] es_q;
  reg [3:0] dig_q;
  reg [1:0] conf_mode_q;
  reg [3:0] key_q;
  reg held_q;
  reg spoiled_q;
  reg started_q;
  reg gate_armed_q;
  reg load_pend_q;
  reg [3:0] load_idx_q;
  reg [9:0] settle_q;
  wire vs_rise;
  wire st_rise;
  wire st_fall;
  wire [3:0] q_head;
  wire key_rel;
  wire key_act;
  reg trig;
  reg sel_en;
  reg [3:0] sel_idx;
  reg [3:0] tgt;
  wire q_restart;
  wire [31:0] dac_full;

  fstc_edge u_vs (
    .mclk(mclk),
    .rst_n(rst_n),
    .sig(vsync),
    .rise(vs_rise),
    .fall()
  );

  fstc_edge u_st (
    .mclk(mclk),
    .rst_n(rst_n),
    .sig(strobe),
    .rise(st_rise),
    .fall(st_fall)
  );

  fstc_queue #(
    .DEPTH(QDEPTH),
    .AW(QAW)
  ) u_q (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(q_wr_en),
    .wr_addr(q_wr_addr),
    .wr_data(q_wr_data),
    .last_addr(q_last),
    .restart(q_restart),
    .step(trig & ~load_pend_q),
    .head(q_head)
  );

  // release of a key that was not both pressed and released during a move
  assign key_rel = held_q & ~key_down;
  assign key_act = key_rel & ~spoiled_q & ~remote;

  // queue restarts whenever a mode is set, remote direct included; an abort keeps its place
  assign q_restart = (rem_mode_valid & remote) | (ms_q == MS_CONF && key_act && key_q == 4'h1);

  // product kept wide, then cut to the dac width; 15 x 400 still fits
  assign dac_full = {28'h0000000, tgt} * `FSTC_DAC_STEP_MV;

  // trigger source depends on the active mode
  always @* begin
    case (mode_out)
      `FSTC_MODE_EDGE: trig = st_rise;
      `FSTC_MODE_FRAME: trig = vs_rise;
      `FSTC_MODE_GATED: trig = vs_rise & gate_armed_q;
      default: trig = 1'b0;
    endcase
  end

  // index selection: keypad entry, remote select, or trigger
  always @* begin
    sel_en = 1'b0;
    sel_idx = 4'h0;
    if (trig) begin
      sel_en = 1'b1;
      sel_idx = load_pend_q ? load_idx_q : q_head;
    end else if (rem_sel_valid && remote) begin
      sel_en = 1'b1;
      sel_idx = rem_sel_idx;
    end else if (key_act && ms_q == MS_MAIN && mode_out == `FSTC_MODE_DIRECT) begin
      if (key_q == `FSTC_KEY_ENTER) begin
        sel_en = 1'b1;
        // a lone 1 then enter is index 1, not a half-typed two-digit entry
        sel_idx = (es_q == ES_DIG || es_q == ES_ONE) ? dig_q : `FSTC_IDX_RESET;
      end else if (key_q <= 4'h9 && es_q == ES_ZERO) begin
        sel_en = 1'b1;
        sel_idx = key_q;
      end else if (key_q <= 4'h5 && es_q == ES_ONE) begin
        sel_en = 1'b1;
        sel_idx = 4'hA + key_q;
      end
    end
  end

  // target of a new selection; applied even when it equals the current index
  always @* begin
    tgt = sel_idx;
  end

  // key capture: remember the code, flag keys pressed mid-move
  // one key at a time: a second key pressed under a held one is not seen
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      key_q <= 4'h0;
      held_q <= 1'b0;
      spoiled_q <= 1'b0;
    end else begin
      held_q <= key_down;
      if (key_down && !held_q) begin
        key_q <= key_code;
        spoiled_q <= busy; // pressed during a move
      end else if (key_down && !busy) begin
        spoiled_q <= 1'b0; // move ended while held: key reads normally
      end
    end
  end

  // remote/local ownership; startup honours waiting commands
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      remote <= 1'b0;
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
      if (!started_q) begin
        remote <= rem_pending;
      end else if (key_rel && key_q == `FSTC_KEY_LOCAL) begin
        // local acts even when its press was spoiled by a move
        remote <= 1'b0;
      end else if (key_act && key_q == `FSTC_KEY_ONLINE) begin
        remote <= 1'b1;
      end
    end
  end

  // digit entry and mode menu machine
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ms_q <= MS_MAIN;
      es_q <= ES_IDLE;
      dig_q <= 4'h0;
      conf_mode_q <= `FSTC_MODE_DIRECT;
      mode_out <= `FSTC_MODE_DIRECT;
      menu_page <= 4'h0;
      fn_strobe <= 1'b0;
      fn_code <= 4'h0;
    end else begin
      fn_strobe <= 1'b0;
      if (rem_mode_valid && remote) begin
        mode_out <= rem_mode;
      end else if (rem_fn_valid && remote) begin
        fn_strobe <= 1'b1;
        fn_code <= rem_fn;
      end else if (key_act) begin
        case (ms_q)
          MS_MAIN: begin
            if (key_q == `FSTC_KEY_MODE) begin
              ms_q <= MS_MENU;
              menu_page <= 4'h0;
              es_q <= ES_IDLE;
            end else if (key_q == `FSTC_KEY_ENTER) begin
              es_q <= ES_IDLE;
            end else if (key_q <= 4'h9) begin
              case (es_q)
                ES_IDLE: begin
                  es_q <= (key_q == 4'h0) ? ES_ZERO : (key_q == 4'h1) ? ES_ONE : ES_DIG;
                  dig_q <= key_q;
                end
                ES_ONE: begin
                  // 1 followed by 6..9 is out of range and dropped
                  es_q <= ES_IDLE;
                end
                default: es_q <= ES_IDLE;
              endcase
            end
          end
          MS_MENU: begin
            if (key_q == 4'h0) begin
              ms_q <= MS_MAIN;
            end else if (key_q == 4'h1) begin
              if (menu_page != 4'h3) begin
                menu_page <= menu_page + 4'h1;
              end
            end else if (key_q == 4'h4 || key_q == 4'h5 || key_q == 4'h6) begin
              ms_q <= MS_CONF;
              conf_mode_q <= (key_q == 4'h4) ? `FSTC_MODE_FRAME :
                             (key_q == 4'h5) ? `FSTC_MODE_EDGE : `FSTC_MODE_GATED;
            end else if (key_q >= 4'h2 && key_q <= 4'h8) begin
              ms_q <= MS_MAIN;
              fn_strobe <= 1'b1;
              fn_code <= key_q;
            end
          end
          MS_CONF: begin
            if (key_q == 4'h1) begin
              mode_out <= conf_mode_q;
              ms_q <= MS_MAIN;
            end else if (key_q == 4'h0) begin
              // abort leaves mode and queue as they were
              ms_q <= MS_MAIN;
            end
          end
          default: ms_q <= MS_MAIN;
        endcase
      end
    end
  end

  // gated mode arming and host preloaded index
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gate_armed_q <= 1'b0;
      load_pend_q <= 1'b0;
      load_idx_q <= 4'h0;
    end else begin
      // a fall in the cycle of the firing sync is lost; the host must fall again
      if (mode_out != `FSTC_MODE_GATED || trig) begin
        gate_armed_q <= 1'b0;
      end else if (st_fall) begin
        gate_armed_q <= 1'b1;
      end
      if (rem_load_valid && remote && mode_out != `FSTC_MODE_DIRECT) begin
        load_pend_q <= 1'b1; // set wins over consume
        load_idx_q <= rem_load_idx;
      end else if (trig) begin
        load_pend_q <= 1'b0;
      end
    end
  end

  // index, dac and busy outputs
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idx_out <= `FSTC_IDX_RESET;
      dac_mv <= {DACW{1'b0}};
      busy <= 1'b0;
      apply_strobe <= 1'b0;
      settle_q <= 10'h000;
    end else begin
      apply_strobe <= sel_en;
      // a new selection restarts the settle window, so busy never gaps
      if (sel_en) begin
        idx_out <= tgt;
        dac_mv <= dac_full[DACW-1:0];
        busy <= 1'b1;
        settle_q <= SETTLE_CYC[9:0];
      end else if (settle_q != 10'h000) begin
        settle_q <= settle_q - 10'h001;
        busy <= (settle_q != 10'h001);
      end
    end
  end
endmodule
`default_nettype wire

// ---- fstc_consts.vh ----
// constants for the filter select and trigger controller
`ifndef FSTC_CONSTS_VH
`define FSTC_CONSTS_VH
// change-timing modes
`define FSTC_MODE_DIRECT 2'h0
`define FSTC_MODE_EDGE 2'h1
`define FSTC_MODE_FRAME 2'h2
`define FSTC_MODE_GATED 2'h3
// key codes: 0..9 digits, then function keys
`define FSTC_KEY_ENTER 4'hA
`define FSTC_KEY_MODE 4'hB
`define FSTC_KEY_LOCAL 4'hC
`define FSTC_KEY_ONLINE 4'hD
`define FSTC_KEY_F1 4'hE
`define FSTC_KEY_F2 4'hF
// function codes reported by the menu
`define FSTC_FN_DARK 4'h2
`define FSTC_FN_SHOW 4'h3
`define FSTC_FN_EDIT 4'h7
`define FSTC_FN_QUEUE 4'h8
// index and dac
`define FSTC_IDX_RESET 4'h0
`define FSTC_IDX_MAX 4'hF
`define FSTC_DAC_STEP_MV 400
// settle time of a path change
`define FSTC_SETTLE_NS 1000
`define FSTC_CLK_NS 4
`endif

// ---- fstc_edge.v ----
// rising and falling edge detector for a synchronous input
`default_nettype none
module fstc_edge (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // signal in, edge pulses out
  input wire sig,
  output wire rise,
  output wire fall
);
  reg last_q;

  // previous sample; reset low so a high start counts as a rise
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 1'b0;
    end else begin
      last_q <= sig;
    end
  end

  assign rise = sig & ~last_q;
  assign fall = ~sig & last_q;
endmodule
`default_nettype wire

// ---- fstc_queue.v ----
// sequence queue storage with a wrapping read pointer
`default_nettype none
module fstc_queue #(
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // programming side
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [3:0] wr_data,
  input wire [AW-1:0] last_addr,
  // step side
  input wire restart,
  input wire step,
  output wire [3:0] head
);
  reg [3:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] rd_q;
  genvar gi;

  // one flip-flop entry per slot
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_ent
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          mem_q[gi] <= 4'h0;
        end else if (wr_en && wr_addr == gi) begin
          mem_q[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // read pointer wraps after the last programmed entry
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= {AW{1'b0}};
    end else if (restart) begin
      rd_q <= {AW{1'b0}};
    end else if (step) begin
      rd_q <= (rd_q == last_addr) ? {AW{1'b0}} : rd_q + 1'b1;
    end
  end

  assign head = mem_q[rd_q];
endmodule
`default_nettype wire

// ---- fstc_assertions.sv ----
// assertion checker bound to the controller top
`default_nettype none
module fstc_chk #(parameter DACW = 13) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // triggers
  input wire logic vsync,
  input wire logic strobe,
  // results
  input wire logic [3:0] idx_out,
  input wire logic busy,
  input wire logic [DACW-1:0] dac_mv,
  input wire logic [1:0] mode_out,
  input wire logic remote,
  input wire logic fn_strobe,
  input wire logic [3:0] fn_code,
  input wire logic [3:0] menu_page,
  input wire logic apply_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] age_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // cycles since last selection, saturating so long idle runs never wrap
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) age_q <= 10'h0;
    else if (apply_strobe) age_q <= 10'h1;
    else if (age_q != 10'h0 && age_q != 10'h3FF) age_q <= age_q + 10'h1;
  end
  reset_clear_a: assert property (disable iff (1'b0) !rst_n |-> idx_out == 4'h0 && mode_out == 2'h0)
    else $error("outputs not cleared in reset");
  dac_scale_a: assert property (dac_mv == idx_out * 400)
    else $error("dac code not index times step");
  idx_apply_a: assert property ($changed(idx_out) |-> apply_strobe && busy)
    else $error("index moved without a selection");
  busy_hold_a: assert property (age_q >= 10'h1 && age_q <= 10'hF8 |-> busy)
    else $error("busy dropped before settling");
  busy_end_a: assert property (age_q >= 10'hFC && !apply_strobe |-> !busy)
    else $error("busy held past settling");
  fn_pulse_a: assert property (fn_strobe |-> (fn_code inside {4'h2, 4'h3, 4'h7, 4'h8}) ##1 !fn_strobe)
    else $error("bad function pulse");
  page_max_a: assert property (menu_page <= 4'h3)
    else $error("menu page beyond last");
  edge_step_a: assert property (mode_out == 2'h1 && $rose(strobe) |-> ##[1:2] apply_strobe)
    else $error("no step on strobe rise");
  frame_step_a: assert property (mode_out == 2'h2 && $rose(vsync) |-> ##[1:2] apply_strobe)
    else $error("no step on vertical sync");
  cover property (fn_strobe);
  cover property (mode_out == 2'h3 && apply_strobe);
  cover property (remote && apply_strobe);
endmodule
bind fstc_top fstc_chk #(.DACW(DACW)) u_chk (.*);
`default_nettype wire

// ---- fstc_cam.sv ----
// camera model giving vertical sync pulses
`default_nettype none
module fstc_cam #(parameter PERIOD = 300) (
  // clock and enable
  input wire logic mclk,
  input wire logic run,
  // sync out
  output var logic vsync
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // two-cycle pulse per frame; a slower camera is just a larger period
  always @(negedge mclk) begin
    cnt = run ? (cnt + 1) % PERIOD : 0;
    vsync <= run && cnt >= PERIOD - 2;
  end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the filter select and trigger controller
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = '0, rst_n = '1, key_down = '0, rem_pending = '0, rem_sel_valid = '0, rem_mode_valid = '0;
  logic rem_fn_valid = '0, rem_load_valid = '0, q_wr_en = '0, strobe = '0, cam_run = '0;
  logic [3:0] key_code = '0, rem_sel_idx = '0, rem_fn = '0, rem_load_idx = '0, q_wr_addr = '0, q_wr_data = '0;
  logic [3:0] q_last = 4'h3;
  logic [1:0] rem_mode = '0;
  logic [31:0] seed = 32'h14E416FB;
  wire [3:0] idx_out, fn_code, menu_page;
  wire [12:0] dac_mv;
  wire [1:0] mode_out;
  wire busy, remote, fn_strobe, apply_strobe, vsync;
  int errors = 0, comparisons = 0, cycles = 0;
  logic [3:0] exp_q[$], fn_q[$];
  fstc_top DUT (.*);
  fstc_cam #(.PERIOD(300)) cam (.mclk(mclk), .run(cam_run), .vsync(vsync));
  always #2 mclk = ~mclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic bad(string m);
    errors++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic complete_run;
    if (exp_q.size() != 0 || fn_q.size() != 0) bad("results missing");
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check_idx(logic [3:0] e);
    comparisons++;
    if (idx_out !== e || dac_mv !== 13'(e * 400) || busy !== 1'h1) bad($sformatf("index %0d want %0d", idx_out, e));
  endtask
  task automatic check_fn(logic [3:0] e);
    comparisons++;
    if (fn_code !== e) bad($sformatf("function %0d want %0d", fn_code, e));
  endtask
  task automatic check_val(logic [3:0] got, logic [3:0] e, string m);
    comparisons++;
    if (got !== e) bad(m);
  endtask
  // key held a random while; action lands on release
  task automatic tap(logic [3:0] c);
    @(negedge mclk);
    key_down = 1'h1;
    key_code = c;
    repeat (1 + xs() % 3) @(negedge mclk);
    key_down = 1'h0;
    @(negedge mclk);
  endtask
  task automatic idle(bit q);
    for (int n = 0; n < 1000 && (q ? exp_q.size() != 0 : busy !== 1'h0); n++) @(negedge mclk);
    if (q ? exp_q.size() != 0 : busy !== 1'h0) bad("no result");
  endtask
  // waits out busy before each key, so no key is lost to a move
  task automatic keys(string s);
    for (int i = 0; i < s.len(); i++) begin
      idle(0);
      tap(s.substr(i, i).atohex());
    end
    idle(1);
  endtask
  task automatic sel(string s, logic [3:0] e);
    exp_q.push_back(e);
    keys(s);
  endtask
  task automatic trig;
    idle(0);
    strobe = 1'h1;
    repeat (3) @(negedge mclk);
    strobe = 1'h0;
    @(negedge mclk);
  endtask
  task automatic rem(logic [3:0] w, logic [3:0] v);
    @(negedge mclk);
    {rem_sel_valid, rem_mode_valid, rem_fn_valid, rem_load_valid} = w;
    {rem_sel_idx, rem_fn, rem_load_idx, rem_mode} = {v, v, v, v[1:0]};
    @(negedge mclk);
    {rem_sel_valid, rem_mode_valid, rem_fn_valid, rem_load_valid} = 4'h0;
    @(negedge mclk);
  endtask
  // results matched in order against the driver's notes
  always @(negedge mclk) begin
    if (apply_strobe === 1'h1 && exp_q.size() == 0) bad("unexpected selection");
    else if (apply_strobe === 1'h1) check_idx(exp_q.pop_front());
    if (fn_strobe === 1'h1 && fn_q.size() == 0) bad("unexpected function");
    else if (fn_strobe === 1'h1) check_fn(fn_q.pop_front());
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      bad("timeout");
      complete_run();
    end
  end
  initial begin
    logic [3:0] qv[4];
    #1 rst_n = 1'h0; // a real falling edge, so the asynchronous reset fires
    repeat (6) @(negedge mclk);
    rst_n = 1'h1;
    @(negedge mclk);
    check_val(idx_out, 4'h0, "start index");
    check_val({2'h0, mode_out}, 4'h0, "start mode");
    check_val({3'h0, remote}, 4'h0, "start control");
    sel("08", 4'h8);
    sel("5A", 4'h5);
    sel("1A", 4'h1);
    sel("13", 4'hD);
    sel("15", 4'hF);
    sel("A", 4'h0);
    exp_q.push_back(4'hC);
    sel("12A", 4'h0);
    sel("05", 4'h5);
    tap(4'h7);
    sel("A", 4'h0);
    $display("keypad test done");
    keys("B1111");
    check_val(menu_page, 4'h3, "last page");
    keys("0");
    sel("07", 4'h7);
    for (int d = 2; d < 9; d++) begin
      if (d < 4 || d > 6) fn_q.push_back(4'(d));
      if (d < 4 || d > 6) keys($sformatf("B%0d", d));
    end
    $display("menu test done");
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk);
      {q_wr_en, q_wr_addr, q_wr_data} = {1'h1, 4'(i), 4'(xs())};
      qv[i] = q_wr_data;
    end
    @(negedge mclk);
    q_wr_en = 1'h0;
    keys("B51");
    check_val({2'h0, mode_out}, 4'h1, "edge mode");
    for (int i = 0; i < 6; i++) begin
      exp_q.push_back(qv[i % 4]);
      trig();
    end
    idle(1);
    keys("B50");
    check_val({2'h0, mode_out}, 4'h1, "aborted mode");
    exp_q.push_back(qv[2]);
    trig();
    $display("edge test done");
    keys("B41");
    exp_q = '{qv[0], qv[1]};
    cam_run = 1'h1;
    idle(1);
    cam_run = 1'h0;
    $display("frame test done");
    strobe = 1'h1;
    keys("B61");
    cam_run = 1'h1;
    repeat (700) @(negedge mclk);
    exp_q.push_back(qv[0]);
    strobe = 1'h0;
    idle(1);
    repeat (400) @(negedge mclk);
    cam_run = 1'h0;
    $display("gated test done");
    rst_n = 1'h0;
    rem_pending = 1'h1;
    repeat (6) @(negedge mclk);
    rst_n = 1'h1;
    @(negedge mclk);
    rem_pending = 1'h0;
    check_val({3'h0, remote}, 4'h1, "remote start");
    rem(4'h4, 4'h1);
    check_val({2'h0, mode_out}, 4'h1, "remote mode");
    rem(4'h1, 4'h9);
    exp_q.push_back(4'h9);
    trig();
    keys("05");
    rem(4'h4, 4'h0);
    check_val({2'h0, mode_out}, 4'h0, "direct again");
    trig();
    exp_q.push_back(4'hB);
    rem(4'h8, 4'hB);
    idle(1);
    fn_q.push_back(4'h3);
    rem(4'h2, 4'h3);
    keys("C");
    check_val({3'h0, remote}, 4'h0, "back to keypad");
    sel("06", 4'h6);
    $display("remote test done");
    complete_run();
  end
endmodule
`default_nettype wire
